// ==== verilog/flash_host.sv ====
// Functional notes
// - poll inside the target, unprotected sector
// - take valid data from a later read
// - after timeout failure, write reset command
// - combine both toggles for sector and mode; code decides on toggle one, only latches toggle two into tog2
// - read twice, compare toggle, unchanged means done
// - toggling with timeout set: recheck, then decide
// - returning monitor restarts check from first step
`timescale 1ns/1ps
`default_nettype none
module flash_host
    import flash_status_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [ADDR_W-1:0] flash_addr_o,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_o
);
    typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT} seq_state_t;
    typedef enum logic [2:0] {P_CMD, P_POLL_A, P_POLL_B, P_FINAL, P_RESET} phase_t;
    typedef struct packed {
        seq_state_t st;
        phase_t ph;
        op_t op;
        logic [2:0] step;
        logic [ADDR_W-1:0] tgt_addr;
        logic [7:0] wdata;
        logic [7:0] prev;
        logic [7:0] last_status;
        logic [7:0] rdata;
        logic busy;
        logic done;
        logic [1:0] result;
        logic tog2;
        logic second;
        logic req;
        logic req_we;
        logic [ADDR_W-1:0] req_addr;
        logic [7:0] req_data;
        logic aw_have;
        logic w_have;
        logic [AXI_AW-1:0] waddr;
        logic [31:0] wbuf;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdat;
    } host_t;

    host_t s_q;
    host_t s_d;
    flash_bus_if bus();

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [2:0] seq_len(input op_t op);
        case (op)
            OP_PROGRAM: return 3'd4;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: return 3'd6;
            OP_CHECK: return 3'd0;
            default: return 3'd1;
        endcase
    endfunction : seq_len

    // {address, data} of one bus cycle in a command sequence
    function automatic logic [ADDR_W+7:0] seq_word(input op_t op, input logic [2:0] step,
                                                  input logic [ADDR_W-1:0] tgt, input logic [7:0] wd);
        logic last;
        last = (step == seq_len(op) - 3'd1);
        if (op == OP_READ) begin
            return {tgt, 8'h00};
        end else if (op == OP_RESET || op == OP_SUSPEND || op == OP_RESUME) begin
            return {tgt, (op == OP_RESET) ? CMD_RESET : (op == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME};
        end else if (last) begin
            if (op == OP_PROGRAM) begin
                return {tgt, wd};
            end else if (op == OP_CHIP_ERASE) begin
                return {UNLOCK_ADDR_A, CMD_CHIP_ERASE};
            end else begin
                return {tgt, CMD_SECTOR_ERASE};
            end
        end else if (step == 3'd0 || step == 3'd3) begin
            return {UNLOCK_ADDR_A, UNLOCK_DATA_A};
        end else if (step == 3'd1 || step == 3'd4) begin
            return {UNLOCK_ADDR_B, UNLOCK_DATA_B};
        end else begin
            return {UNLOCK_ADDR_A, (op == OP_PROGRAM) ? CMD_PROGRAM_SETUP : CMD_ERASE_SETUP};
        end
    endfunction : seq_word

    always_comb begin
        logic [31:0] m;
        logic [2:0] nstep;
        m = 32'h0;
        nstep = s_q.step + 3'd1;
        s_d = s_q;
        s_d.req = 1'b0;

        // register writes: address and data may arrive in either order
        if (s_axi_awvalid_i && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.waddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.wbuf = s_axi_wdata_i;
            s_d.wstrb = s_axi_wstrb_i;
        end
        if (s_q.bvalid && s_axi_bready_i) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.waddr)
                REG_CTRL: begin
                    // a start while busy is dropped, the running operation is not disturbed
                    if (!s_q.busy && s_q.wstrb[0]) begin
                        s_d.op = op_t'(s_q.wbuf[2:0]);
                        s_d.busy = 1'b1;
                        s_d.done = 1'b0;
                        s_d.result = RES_NONE;
                        s_d.tog2 = 1'b0;
                        s_d.second = 1'b0;
                        s_d.step = 3'd0;
                        s_d.st = M_ISSUE;
                        s_d.ph = (op_t'(s_q.wbuf[2:0]) == OP_CHECK) ? P_POLL_A : P_CMD;
                    end
                end
                REG_ADDR: begin
                    if (!s_q.busy) begin
                        m = merge({13'h0, s_q.tgt_addr}, s_q.wbuf, s_q.wstrb);
                        s_d.tgt_addr = m[ADDR_W-1:0];
                    end
                end
                REG_DATA: begin
                    if (!s_q.busy && s_q.wstrb[0]) begin
                        s_d.wdata = s_q.wbuf[7:0];
                    end
                end
                REG_STATUS, REG_RDATA: ;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end

        if (s_axi_arvalid_i && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdat = 32'h0;
            case (s_axi_araddr_i)
                REG_CTRL: s_d.rdat = {29'h0, s_q.op};
                REG_ADDR: s_d.rdat = {13'h0, s_q.tgt_addr};
                REG_DATA: s_d.rdat = {24'h0, s_q.wdata};
                REG_STATUS: begin
                    s_d.rdat[STAT_BUSY] = s_q.busy;
                    s_d.rdat[STAT_DONE] = s_q.done;
                    s_d.rdat[STAT_RESULT_LSB +: 2] = s_q.result;
                    s_d.rdat[STAT_TOG2] = s_q.tog2;
                    s_d.rdat[STAT_BYTE_LSB +: 8] = s_q.last_status;
                end
                REG_RDATA: s_d.rdat = {24'h0, s_q.rdata};
                default: s_d.rresp = RESP_SLVERR;
            endcase
        end else if (s_q.rvalid && s_axi_rready_i) begin
            s_d.rvalid = 1'b0;
        end

        case (s_q.st)
            M_IDLE: ;
            M_ISSUE: begin
                s_d.req = 1'b1;
                if (s_q.ph == P_CMD) begin
                    {s_d.req_addr, s_d.req_data} = seq_word(s_q.op, s_q.step, s_q.tgt_addr, s_q.wdata);
                    s_d.req_we = (s_q.op != OP_READ);
                end else if (s_q.ph == P_RESET) begin
                    s_d.req_addr = s_q.tgt_addr;
                    s_d.req_data = CMD_RESET;
                    s_d.req_we = 1'b1;
                end else begin
                    // status reads stay inside the operation's own sector
                    s_d.req_addr = s_q.tgt_addr;
                    s_d.req_data = 8'h00;
                    s_d.req_we = 1'b0;
                end
                s_d.st = M_WAIT;
            end
            M_WAIT: begin
                if (bus.ack) begin
                    s_d.st = M_ISSUE;
                    case (s_q.ph)
                        P_CMD: begin
                            s_d.step = nstep;
                            if (nstep == seq_len(s_q.op)) begin
                                if (s_q.op == OP_PROGRAM || s_q.op == OP_CHIP_ERASE
                                    || s_q.op == OP_SECTOR_ERASE) begin
                                    // status is only meaningful after the final command strobe
                                    s_d.ph = P_POLL_A;
                                end else begin
                                    s_d.rdata = bus.rd_data;
                                    s_d.result = RES_PASS;
                                    s_d.done = 1'b1;
                                    s_d.busy = 1'b0;
                                    s_d.st = M_IDLE;
                                end
                            end
                        end
                        P_POLL_A: begin
                            s_d.prev = bus.rd_data;
                            s_d.ph = P_POLL_B;
                        end
                        P_POLL_B: begin
                            s_d.last_status = bus.rd_data;
                            if (s_q.prev[TOGGLE_TWO_BIT] != bus.rd_data[TOGGLE_TWO_BIT]) begin
                                s_d.tog2 = 1'b1;
                            end
                            if (s_q.prev[TOGGLE_ONE_BIT] == bus.rd_data[TOGGLE_ONE_BIT]) begin
                                s_d.ph = P_FINAL;
                            end else if (s_q.second) begin
                                s_d.ph = P_RESET;
                            end else if (bus.rd_data[TIMEOUT_ERROR_BIT]) begin
                                s_d.second = 1'b1;
                                s_d.ph = P_POLL_A;
                            end else begin
                                // protected targets stop toggling on their own, so no time limit here
                                s_d.ph = P_POLL_A;
                            end
                        end
                        P_FINAL: begin
                            // the read that saw toggling stop may carry stale low bits
                            s_d.rdata = bus.rd_data;
                            s_d.result = RES_PASS;
                            s_d.done = 1'b1;
                            s_d.busy = 1'b0;
                            s_d.st = M_IDLE;
                        end
                        P_RESET: begin
                            s_d.result = RES_FAIL;
                            s_d.done = 1'b1;
                            s_d.busy = 1'b0;
                            s_d.st = M_IDLE;
                        end
                        default: s_d.st = M_IDLE;
                    endcase
                end
            end
            default: s_d.st = M_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.req = s_q.req;
    assign bus.req_we = s_q.req_we;
    assign bus.req_addr = s_q.req_addr;
    assign bus.req_data = s_q.req_data;
    assign bus.dq_i = flash_dq_i;

    flash_cycle u_cycle (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .bus(bus.engine)
    );

    assign s_axi_awready_o = !s_q.aw_have;
    assign s_axi_wready_o = !s_q.w_have;
    assign s_axi_bvalid_o = s_q.bvalid;
    assign s_axi_bresp_o = s_q.bresp;
    assign s_axi_arready_o = !s_q.rvalid;
    assign s_axi_rvalid_o = s_q.rvalid;
    assign s_axi_rresp_o = s_q.rresp;
    assign s_axi_rdata_o = s_q.rdat;
    assign flash_addr_o = bus.addr;
    assign flash_ce_n_o = bus.ce_n;
    assign flash_oe_n_o = bus.oe_n;
    assign flash_we_n_o = bus.we_n;
    assign flash_dq_o = bus.dq_o;
    assign flash_dq_oe_o = bus.dq_oe;
endmodule : flash_host
`default_nettype wire

// ==== verilog/flash_status_pkg.sv ====
package flash_status_pkg;
    localparam int CLK_MHZ = 100;
    localparam int T_SETUP_NS = 10;
    localparam int T_STROBE_NS = 70;
    localparam int T_RECOVER_NS = 30;
    // least times, rounded up to whole cycles
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RECOVER_CYC = 8'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);

    localparam int ADDR_W = 19;
    localparam int AXI_AW = 8;

    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_ADDR = 8'h04;
    localparam logic [AXI_AW-1:0] REG_DATA = 8'h08;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0c;
    localparam logic [AXI_AW-1:0] REG_RDATA = 8'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int POLL_BIT = 7;
    localparam int TOGGLE_ONE_BIT = 6;
    localparam int TIMEOUT_ERROR_BIT = 5;
    localparam int ERASE_START_BIT = 3;
    localparam int TOGGLE_TWO_BIT = 2;

    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_RESULT_LSB = 2;
    localparam int STAT_TOG2 = 4;
    localparam int STAT_BYTE_LSB = 8;

    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_PASS = 2'h1;
    localparam logic [1:0] RES_FAIL = 2'h2;

    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h002aa;
    localparam logic [7:0] UNLOCK_DATA_A = 8'haa;
    localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0] CMD_PROGRAM_SETUP = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;

    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_RESET,
        OP_SUSPEND,
        OP_RESUME,
        OP_CHECK
    } op_t;
endpackage : flash_status_pkg

// ==== verilog/flash_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface flash_bus_if;
    import flash_status_pkg::*;
    logic req;
    logic req_we;
    logic [ADDR_W-1:0] req_addr;
    logic [7:0] req_data;
    logic ack;
    logic [7:0] rd_data;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic [7:0] dq_i;
    modport engine(input req, req_we, req_addr, req_data, dq_i,
                   output ack, rd_data, ce_n, oe_n, we_n, addr, dq_o, dq_oe);
    modport ctrl(output req, req_we, req_addr, req_data, dq_i,
                 input ack, rd_data, ce_n, oe_n, we_n, addr, dq_o, dq_oe);
endinterface : flash_bus_if
`default_nettype wire

// ==== verilog/flash_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
    import flash_status_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    flash_bus_if.engine bus
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_RECOVER} cyc_state_t;
    typedef struct packed {
        cyc_state_t st;
        logic [7:0] cnt;
        logic we;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
        logic ack;
        logic [7:0] rd;
    } cyc_t;

    localparam cyc_t CYC_RESET = '{st: C_IDLE, cnt: 8'h00, we: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                                   we_n: 1'b1, addr: '0, dq_o: 8'h00, dq_oe: 1'b0, ack: 1'b0,
                                   rd: 8'h00};
    cyc_t s_q;
    cyc_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        case (s_q.st)
            C_IDLE: begin
                if (bus.req) begin
                    s_d.we = bus.req_we;
                    s_d.addr = bus.req_addr;
                    s_d.dq_o = bus.req_data;
                    s_d.dq_oe = bus.req_we;
                    s_d.ce_n = 1'b0;
                    s_d.cnt = SETUP_CYC - 8'h01;
                    s_d.st = C_SETUP;
                end
            end
            C_SETUP: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.oe_n = s_q.we;
                    s_d.we_n = !s_q.we;
                    s_d.cnt = STROBE_CYC - 8'h01;
                    s_d.st = C_STROBE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            C_STROBE: begin
                if (s_q.cnt == 8'h00) begin
                    // every read is closed by raising both selects, so the next is a new cycle
                    if (!s_q.we) begin
                        s_d.rd = bus.dq_i;
                    end
                    s_d.oe_n = 1'b1;
                    s_d.we_n = 1'b1;
                    s_d.ce_n = 1'b1;
                    s_d.cnt = RECOVER_CYC - 8'h01;
                    s_d.st = C_RECOVER;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            C_RECOVER: begin
                // data held past the strobe's rising edge for one cycle
                s_d.dq_oe = 1'b0;
                if (s_q.cnt == 8'h00) begin
                    s_d.ack = 1'b1;
                    s_d.st = C_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: s_d = CYC_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q <= CYC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.ack = s_q.ack;
    assign bus.rd_data = s_q.rd;
    assign bus.ce_n = s_q.ce_n;
    assign bus.oe_n = s_q.oe_n;
    assign bus.we_n = s_q.we_n;
    assign bus.addr = s_q.addr;
    assign bus.dq_o = s_q.dq_o;
    assign bus.dq_oe = s_q.dq_oe;
endmodule : flash_cycle
`default_nettype wire

// ==== sim/flash_host_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts
    import flash_status_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_we_n_o,
    input wire logic flash_dq_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not held");
    property p_rans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    // every read is a fresh strobe, so the device advances its toggle
    property p_oe_len; $fell(flash_oe_n_o) |-> !flash_oe_n_o [*7] ##1 flash_oe_n_o; endproperty
    a_oe_len: assert property (p_oe_len) else $error("read strobe width wrong");
    property p_we_len; $fell(flash_we_n_o) |-> !flash_we_n_o [*7] ##1 flash_we_n_o; endproperty
    a_we_len: assert property (p_we_len) else $error("write strobe width wrong");
    property p_setup; $fell(flash_oe_n_o) || $fell(flash_we_n_o) |-> $past(!flash_ce_n_o) && !flash_ce_n_o;
    endproperty
    a_setup: assert property (p_setup) else $error("strobe without select setup");
    property p_nodrive; !flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o; endproperty
    a_nodrive: assert property (p_nodrive) else $error("host drives bus during read");
    property p_addr; !flash_oe_n_o && $past(!flash_oe_n_o) |-> $stable(flash_addr_o); endproperty
    a_addr: assert property (p_addr) else $error("poll address moved");
endmodule : flash_host_asserts
`default_nettype wire

// ==== sim/flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_model
    import flash_status_pkg::*;
#(parameter int BUSY_READS = 4) (
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem_q [16];
    logic [7:0] last_q = 8'h00;
    logic [7:0] prog_q = 8'h00;
    logic [7:0] rel_q = 8'h00;
    logic tog_q = 1'b0;
    logic err_q = 1'b0;
    logic bad_q = 1'b0;
    logic erase_q = 1'b0;
    int busy_q = 0;
    initial foreach (mem_q[i]) mem_q[i] = 8'hff;
    // released bus shows the inverse of the last value, never a kind leftover
    always @(dq_o) if (!(ce_n_i || oe_n_i)) rel_q = ~dq_o;
    always_comb begin
        if (ce_n_i || oe_n_i) dq_o = rel_q;
        else if (busy_q == 0) dq_o = mem_q[addr_i[3:0]];
        else if (erase_q) dq_o = {1'b0, tog_q, err_q, 2'b01, tog_q, 2'b00};
        else dq_o = {~prog_q[7], tog_q, err_q, prog_q[4:0]};
    end
    always @(posedge oe_n_i) begin
        if (busy_q > 0) begin
            tog_q <= ~tog_q;
            if (busy_q > 1 || !bad_q) busy_q <= busy_q - 1;
            else err_q <= 1'b1;
        end
    end
    always @(posedge we_n_i) begin
        last_q <= dq_i;
        if (dq_i == CMD_RESET) begin
            busy_q <= 0;
            err_q <= 1'b0;
        end else if (busy_q == 0 && last_q == CMD_PROGRAM_SETUP) begin
            prog_q <= dq_i;
            erase_q <= 1'b0;
            busy_q <= BUSY_READS;
            bad_q <= |(dq_i & ~mem_q[addr_i[3:0]]);
            mem_q[addr_i[3:0]] <= mem_q[addr_i[3:0]] & dq_i;
        end else if (busy_q == 0 && last_q == UNLOCK_DATA_B && dq_i inside {CMD_CHIP_ERASE, CMD_SECTOR_ERASE}) begin
            erase_q <= 1'b1;
            bad_q <= 1'b0;
            busy_q <= BUSY_READS;
            foreach (mem_q[i]) mem_q[i] <= 8'hff;
        end
    end
endmodule : flash_model
`default_nettype wire

// ==== sim/tb_flash_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_flash_host;
    import flash_status_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] faddr;
    logic [7:0] dq_h, dq_f;
    int err_total = 0;
    int cmp_count = 0;
    flash_host dut_u (.ref_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .flash_addr_o(faddr),
        .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_dq_i(dq_f), .flash_dq_o(dq_h),
        .flash_dq_oe_o(dq_oe));
    flash_model model_u (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(faddr), .dq_i(dq_h), .dq_o(dq_f));
    initial forever #5 clk = ~clk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic limit(input int n);
        if (n >= 400) begin
            err_total++;
            complete_run();
        end
    endtask : limit
    // ready is sampled mid-cycle, where it equals its value at the next edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa = 1'b1;
        logic pw = 1'b1;
        logic pb = 1'b1;
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pb && n < 400) begin
            @(negedge clk);
            if (awready) pa = 1'b0;
            if (wready) pw = 1'b0;
            if (bvalid) pb = 1'b0;
            r = bresp;
            @(posedge clk);
            awvalid <= pa;
            wvalid <= pw;
            bready <= pb;
            n++;
        end
        limit(n);
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa = 1'b1;
        logic pr = 1'b1;
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (pr && n < 400) begin
            @(negedge clk);
            if (arready) pa = 1'b0;
            if (rvalid) pr = 1'b0;
            d = rdata;
            r = rresp;
            @(posedge clk);
            arvalid <= pa;
            rready <= pr;
            n++;
        end
        limit(n);
    endtask : axr
    task automatic run(input logic [7:0] adr, input logic [7:0] dat, input op_t op, output logic [31:0] s);
        logic [1:0] r;
        int n = 0;
        axw(REG_ADDR, {24'h0, adr}, r);
        axw(REG_DATA, {24'h0, dat}, r);
        axw(REG_CTRL, {29'h0, op}, r);
        s = 32'h1;
        while (!(s[STAT_DONE] === 1'b1 && s[STAT_BUSY] === 1'b0) && n < 400) begin
            axr(REG_STATUS, s, r);
            n++;
        end
        limit(n);
    endtask : run
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0] r;
        axr(REG_STATUS, d, r);
        chk("status at reset", 32'h0, d);
        axw(8'h40, 32'h1, r);
        chk("unmapped write resp", RESP_SLVERR, r);
        axr(8'h40, d, r);
        chk("unmapped read resp", RESP_SLVERR, r);
    endtask : t_bus
    task automatic t_prog(input logic [7:0] dat, input logic [1:0] res);
        logic [31:0] s, d;
        logic [1:0] r;
        run(8'h03, dat, OP_PROGRAM, s);
        chk("program result", res, s[STAT_RESULT_LSB +: 2]);
        chk("device idle after", 32'h0, model_u.busy_q);
        run(8'h03, 8'h00, OP_READ, s);
        axr(REG_RDATA, d, r);
        chk("array byte", 32'h5a, d);
    endtask : t_prog
    task automatic t_erase();
        op_t ops [2] = '{OP_SECTOR_ERASE, OP_CHIP_ERASE};
        logic [31:0] s, d;
        logic [1:0] r;
        foreach (ops[i]) begin
            run(8'h03, 8'h00, ops[i], s);
            chk("erase result", RES_PASS, s[STAT_RESULT_LSB +: 2]);
            chk("toggle two seen", 32'h1, s[STAT_TOG2]);
            axr(REG_RDATA, d, r);
            chk("erased byte", 32'hff, d);
        end
        run(8'h03, 8'h00, OP_CHECK, s);
        chk("check result", RES_PASS, s[STAT_RESULT_LSB +: 2]);
    endtask : t_erase
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_bus();
        t_prog(8'h5a, RES_PASS);
        t_prog(8'hff, RES_FAIL);
        t_erase();
        complete_run();
    end
endmodule : tb_flash_host
bind flash_host flash_host_asserts chk_u (.*);
`default_nettype wire
